// ---- rtl/adc_cal_core.sv ----
// Functional notes
// R1: offset is 15-bit two's complement in quarter-LSB steps, zero means none.
// R2: gain-9 offset applies only to auxiliary channel conversions taken at amplifier gain 9.
// R3: gain coefficient scales result, 0x4000 unity, 0x2000 half.
// R4: gain coefficient zero forces a zero corrected result.
// R5: gain-9 gain applies only to auxiliary channel conversions taken at amplifier gain 9.
// R6: temperature offset applies only to temperature sensor conversions.
// R7: gain-9 gain coefficient resets to 0x4000.
// R8: both offset coefficients reset to zero.
// R9: coefficient register bits 31 to 15 read zero and ignore writes.
// R10: offset added before gain scaling, result saturated to word range.
`timescale 1ns/100ps
`default_nettype none
module adc_cal_core
	import adc_cal_pkg::*;
(
	// clock, reset, enable
	input wire logic core_clk,
	input wire logic reset,
	input wire logic clk_en,
	// wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [15:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	output logic wb_err_o,
	// raw sample path
	input wire logic raw_valid,
	input wire adc_cal_pkg::raw_sample_s raw_sample,
	// corrected result
	output logic result_valid,
	output adc_cal_pkg::result_s converter_result_word
);
	import adc_cal_pkg::*;

	logic [14:0] temp_offset_q;
	logic [14:0] gain9_gain_q;
	logic [14:0] gain9_offset_q;
	logic [31:0] dat_q;
	logic ack_q;
	logic err_q;
	logic valid_q;
	result_s result_q;
	coef_s coef_d;
	logic [15:0] corrected;
	logic bus_req;
	logic hit;
	logic [31:0] rd_d;

	// merge 15-bit field with byte enables
	function automatic logic [14:0] merge_field(input logic [14:0] old,
		input logic [31:0] wdat, input logic [3:0] sel);
		logic [14:0] v;
		v = old;
		if (sel[0]) begin
			v[7:0] = wdat[7:0];
		end
		if (sel[1]) begin
			v[14:8] = wdat[14:8];
		end
		return v;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// register bus

	assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;

	// address decode and read mux
	always_comb begin
		hit = 1'b1;
		rd_d = 32'h0000_0000;
		case (wb_adr_i)
			TEMP_OFFSET_ADDR: rd_d = {17'h0, temp_offset_q}; // R9
			GAIN9_GAIN_ADDR: rd_d = {17'h0, gain9_gain_q}; // R9
			GAIN9_OFFSET_ADDR: rd_d = {17'h0, gain9_offset_q}; // R9
			STATUS_ADDR: rd_d = {14'h0, result_q.channel, result_q.data};
			default: hit = 1'b0;
		endcase
	end

	// ack or err held for one enabled cycle, dropped at the next edge with clk_en high
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			ack_q <= 1'b0;
			err_q <= 1'b0;
			dat_q <= 32'h0000_0000;
		end else if (clk_en) begin
			ack_q <= bus_req && hit;
			err_q <= bus_req && !hit;
			dat_q <= (bus_req && hit && !wb_we_i) ? rd_d : 32'h0000_0000;
		end
	end

	// coefficient writes
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			temp_offset_q <= OFFSET_ZERO; // R8
			gain9_offset_q <= OFFSET_ZERO; // R8
			gain9_gain_q <= GAIN_UNITY; // R7
		end else if (clk_en && bus_req && wb_we_i) begin
			case (wb_adr_i)
				TEMP_OFFSET_ADDR: begin
					temp_offset_q <= merge_field(temp_offset_q, wb_dat_i,
						wb_sel_i); // R9
				end
				GAIN9_GAIN_ADDR: begin
					gain9_gain_q <= merge_field(gain9_gain_q, wb_dat_i,
						wb_sel_i); // R9
				end
				GAIN9_OFFSET_ADDR: begin
					gain9_offset_q <= merge_field(gain9_offset_q, wb_dat_i,
						wb_sel_i); // R9
				end
				default: begin
				end
			endcase
		end
	end

	assign wb_ack_o = ack_q;
	assign wb_err_o = err_q;
	assign wb_dat_o = dat_q;

	////////////////////////////////////////////////////////////////////////
	// coefficient selection

	always_comb begin
		coef_d.offset = OFFSET_ZERO;
		coef_d.gain = GAIN_UNITY;
		case (raw_sample.channel)
			CH_TEMP: coef_d.offset = temp_offset_q; // R6
			CH_AUX: begin
				if (raw_sample.pga_gain == PGA_GAIN9) begin
					coef_d.offset = gain9_offset_q; // R2
					coef_d.gain = gain9_gain_q; // R5
				end
			end
			default: begin
			end
		endcase
	end

	adc_cal_math u_math (
		.raw(raw_sample.data),
		.coef(coef_d),
		.result(corrected)
	);

	////////////////////////////////////////////////////////////////////////
	// result register

	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			valid_q <= 1'b0;
			result_q <= '0;
		end else if (clk_en) begin
			valid_q <= raw_valid;
			if (raw_valid) begin
				result_q.data <= corrected; // R10
				result_q.channel <= raw_sample.channel;
			end
		end
	end

	assign result_valid = valid_q;
	assign converter_result_word = result_q;

endmodule
`default_nettype wire

// ---- rtl/adc_cal_math.sv ----
`timescale 1ns/100ps
`default_nettype none
module adc_cal_math
	import adc_cal_pkg::*;
(
	// operands
	input wire logic [15:0] raw,
	input wire adc_cal_pkg::coef_s coef,
	// corrected word
	output logic [15:0] result
);
	import adc_cal_pkg::*;

	logic signed [35:0] sum_q2;
	logic signed [51:0] prod;
	logic signed [51:0] scaled;

	// raw in quarter steps plus signed offset, then gain, then clamp
	always_comb begin
		sum_q2 = $signed({18'h00000, raw, 2'b00})
			+ 36'($signed(coef.offset)); // R1 R10
		prod = 52'(sum_q2) * $signed({37'h0, coef.gain}); // R3
		scaled = prod >>> (GAIN_FRAC + OFFSET_FRAC);
		if (coef.gain == '0) begin
			result = RESULT_ZERO; // R4
		end else if (scaled < 0) begin
			result = RESULT_ZERO; // R10
		end else if (scaled > $signed({36'h0, RESULT_MAX})) begin
			result = RESULT_MAX; // R10
		end else begin
			result = scaled[15:0];
		end
	end

endmodule
`default_nettype wire

// ---- rtl/adc_cal_pkg.sv ----
package adc_cal_pkg;

	// register byte addresses
	localparam logic [15:0] TEMP_OFFSET_ADDR = 16'h223C;
	localparam logic [15:0] GAIN9_GAIN_ADDR = 16'h2298;
	localparam logic [15:0] GAIN9_OFFSET_ADDR = 16'h22D0;
	// own status register: last corrected word and last channel
	localparam logic [15:0] STATUS_ADDR = 16'h2300;

	// coefficient field
	localparam int COEF_W = 15;
	localparam logic [14:0] GAIN_UNITY = 15'h4000;
	localparam logic [14:0] OFFSET_ZERO = 15'h0000;
	localparam int GAIN_FRAC = 14;
	localparam int OFFSET_FRAC = 2;

	// result word
	localparam int RESULT_W = 16;
	localparam logic [15:0] RESULT_MAX = 16'hFFFF;
	localparam logic [15:0] RESULT_ZERO = 16'h0000;

	// amplifier gain code for gain of 9
	localparam logic [2:0] PGA_GAIN9 = 3'h4;

	typedef enum logic [1:0] {
		CH_AUX,
		CH_TIA,
		CH_TEMP
	} channel_e;

	// raw conversion from the sample path
	typedef struct packed {
		logic [15:0] data;
		logic [2:0] pga_gain;
		channel_e channel;
	} raw_sample_s;

	// corrected conversion to the result register
	typedef struct packed {
		logic [15:0] data;
		channel_e channel;
	} result_s;

	// selected coefficients
	typedef struct packed {
		logic [14:0] offset;
		logic [14:0] gain;
	} coef_s;

endpackage

// ---- verif/adc_cal_core_assertions.sv ----
`timescale 1ns/100ps
`default_nettype none
module adc_cal_chk
	import adc_cal_pkg::*;
(
	// bus and sample ports
	input wire logic core_clk,
	input wire logic reset,
	input wire logic clk_en,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic [15:0] wb_adr_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	input wire logic wb_err_o,
	input wire logic raw_valid,
	input wire logic result_valid
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (reset);
	////////////////
	// bus answers
	rsp_next_a: assert property (clk_en && wb_cyc_i && wb_stb_i &&
		!wb_ack_o && !wb_err_o |=> wb_ack_o ^ wb_err_o)
		else $error("no answer");
	ack_pulse_a: assert property (wb_ack_o && clk_en |=> !wb_ack_o)
		else $error("ack long");
	err_pulse_a: assert property (wb_err_o && clk_en |-> !wb_ack_o
		##1 !wb_err_o) else $error("err long");
	rsp_cause_a: assert property ((wb_ack_o || wb_err_o) && $past(clk_en)
		|-> $past(wb_cyc_i && wb_stb_i)) else $error("stray answer");
	rd_idle_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
		else $error("data idle");
	hi_zero_a: assert property (wb_ack_o && wb_adr_i != STATUS_ADDR |->
		wb_dat_o[31:15] == 17'h0) else $error("upper bits");
	// sample path
	res_lat_a: assert property (raw_valid && clk_en |=> result_valid)
		else $error("no result");
	res_cause_a: assert property (result_valid && $past(clk_en) |->
		$past(raw_valid)) else $error("stray result");
	cover property (wb_err_o);
	cover property (raw_valid && !clk_en);
	cover property (wb_ack_o ##2 wb_ack_o);
	cover property (result_valid);
endmodule
bind adc_cal_core adc_cal_chk u_chk (.core_clk, .reset, .clk_en, .wb_cyc_i,
	.wb_stb_i, .wb_adr_i, .wb_dat_o, .wb_ack_o, .wb_err_o, .raw_valid,
	.result_valid);
`default_nettype wire

// ---- verif/adc_raw_src.sv ----
`timescale 1ns/100ps
`default_nettype none
module adc_raw_src
	import adc_cal_pkg::*;
(
	// sample path
	input wire logic core_clk,
	output logic raw_valid,
	output adc_cal_pkg::raw_sample_s raw_sample
);
	// idle until a sample is sent
	initial begin
		raw_valid = 1'b0;
		raw_sample = '0;
	end
	// one pulse, then data no longer valid
	task automatic send(input raw_sample_s s);
		@(posedge core_clk);
		raw_valid <= 1'b1;
		raw_sample <= s;
		@(posedge core_clk);
		raw_valid <= 1'b0;
		raw_sample.data <= ~s.data;
	endtask
endmodule
`default_nettype wire

// ---- verif/tb_adc_cal_core.sv ----
`timescale 1ns/100ps
`default_nettype none
module tb_adc_cal_core;
	import adc_cal_pkg::*;
	logic core_clk = 0, reset = 1, cyc = 0, stb = 0, we = 0;
	logic [15:0] adr = '0;
	logic [31:0] wdat = '0, rdat;
	logic ack, err, raw_valid, result_valid;
	logic clk_en = 1;
	logic [3:0] sel = 4'hF;
	raw_sample_s raw_sample;
	result_s res;
	int error_cnt = 0, compares = 0;
	always #20 core_clk = ~core_clk;
	adc_cal_core u_dut (.core_clk, .reset, .clk_en, .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
		.wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .wb_err_o(err),
		.raw_valid, .raw_sample, .result_valid, .converter_result_word(res));
	adc_raw_src u_src (.core_clk, .raw_valid, .raw_sample);
	////////////////
	// compare and count
	task automatic chk(input logic [31:0] seen, exp);
		compares++;
		if (seen !== exp) begin
			error_cnt++;
			$display("ERROR %0t: got %h want %h", $time, seen, exp);
		end
	endtask
	// one bus cycle, error gives EEEEEEEE
	task automatic wb(input logic w, input logic [15:0] a,
		input logic [31:0] d, output logic [31:0] q);
		@(posedge core_clk);
		{cyc, stb, we, adr, wdat} <= {2'b11, w, a, d};
		do @(posedge core_clk); while (!ack && !err);
		q = err ? 32'hEEEEEEEE : rdat;
		{cyc, stb} <= 2'b00;
	endtask
	// program coefficients, send one sample, judge result
	task automatic cal(input logic [14:0] o9, g9, ot,
		input raw_sample_s s, input logic [15:0] exp);
		logic [31:0] q;
		wb(1, GAIN9_OFFSET_ADDR, {17'h0, o9}, q);
		wb(1, GAIN9_GAIN_ADDR, {17'h0, g9}, q);
		wb(1, TEMP_OFFSET_ADDR, {17'h0, ot}, q);
		u_src.send(s);
		#1;
		chk({31'h0, result_valid}, 32'h1);
		chk({16'h0, res.data}, {16'h0, exp});
		chk({30'h0, res.channel}, {30'h0, s.channel});
	endtask
	////////////////
	// reset values, masking, unmapped place
	task automatic t_regs;
		logic [31:0] q;
		wb(0, TEMP_OFFSET_ADDR, 0, q);
		chk(q, 32'h0);
		wb(0, GAIN9_OFFSET_ADDR, 0, q);
		chk(q, 32'h0);
		wb(0, GAIN9_GAIN_ADDR, 0, q);
		chk(q, 32'h4000);
		wb(1, GAIN9_OFFSET_ADDR, 32'hFFFFFFFF, q);
		wb(0, GAIN9_OFFSET_ADDR, 0, q);
		chk(q, 32'h7FFF);
		sel <= 4'h1;
		wb(1, GAIN9_OFFSET_ADDR, 0, q);
		sel <= 4'hF;
		wb(0, GAIN9_OFFSET_ADDR, 0, q);
		chk(q, 32'h7F00);
		wb(0, 16'h2000, 0, q);
		chk(q, 32'hEEEEEEEE);
		$display("registers done");
	endtask
	// correction cases
	task automatic t_math;
		logic [31:0] q;
		cal(15'h7FFF, 15'h4000, 0, '{100, PGA_GAIN9, CH_AUX}, 99);
		cal(15'h4000, 15'h4000, 0, '{100, PGA_GAIN9, CH_AUX}, 0);
		cal(15'h1, 15'h2000, 0, '{1000, PGA_GAIN9, CH_AUX}, 500);
		cal(0, 0, 0, '{1000, PGA_GAIN9, CH_AUX}, 0);
		cal(15'h3FFF, 15'h2000, 0, '{1000, 3'h0, CH_AUX}, 1000);
		cal(15'h3FFF, 15'h2000, 0, '{1000, PGA_GAIN9, CH_TIA}, 1000);
		cal(15'h3FFF, 15'h2000, 15'h3FFF, '{100, PGA_GAIN9, CH_TEMP}, 4195);
		cal(0, 15'h7FFF, 0, '{16'hFFFF, PGA_GAIN9, CH_AUX}, 16'hFFFF);
		wb(0, STATUS_ADDR, 0, q);
		chk(q, 32'h0000FFFF);
		$display("correction done");
	endtask
	// clock enable low: a sample is not taken, result holds
	task automatic t_freeze;
		@(posedge core_clk);
		clk_en <= 1'b0;
		u_src.send('{16'h0123, 3'h0, CH_AUX});
		#1;
		chk({31'h0, result_valid}, 32'h0);
		chk({16'h0, res.data}, 32'h0000FFFF);
		@(posedge core_clk);
		clk_en <= 1'b1;
		$display("freeze done");
	endtask
	// verdict
	task automatic finish_test;
		$display("compares %0d errors %0d", compares, error_cnt);
		if (error_cnt == 0 && compares > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	// main sequence
	initial begin
		repeat (16) @(posedge core_clk);
		reset <= 0;
		t_regs;
		t_math;
		t_freeze;
		finish_test;
	end
	// watchdog
	initial begin
		#200000;
		error_cnt++;
		finish_test;
	end
endmodule
`default_nettype wire
